// ===== rtl/input_cond_pkg.sv
/*
  Constants for the input conditioning block: register offsets, field
  positions, reset values and timing counts.
  Assumes a 200 MHz core clock and a plain single-cycle register port.
*/
package input_cond_pkg;

    // Register offsets (byte addresses)
    localparam logic [7:0] DELAY_REG    = 8'h00;
    localparam logic [7:0] PCATCH_REG   = 8'h04;
    localparam logic [7:0] AFEN_REG     = 8'h08;
    localparam logic [7:0] AFCNT_REG    = 8'h0c;
    localparam logic [7:0] DEADBAND_REG = 8'h10;
    localparam logic [7:0] RAW_REG      = 8'h14;
    localparam logic [7:0] FILT_REG     = 8'h18;
    localparam logic [7:0] IMAGE_REG    = 8'h1c;

    // Delay code per group: delay = 0.2 ms * 2^code
    localparam int         DELAY_CODE_W   = 3;
    localparam int         DELAY_FIELD_W  = 4;
    localparam logic [2:0] DELAY_CODE_MAX = 3'h6;
    localparam logic [2:0] DELAY_CODE_RST = 3'h5;
    localparam int         DELAY_TICKS_W  = 7;

    // Base delay step and core clock
    localparam int DELAY_BASE_US = 200;
    localparam int CLK_MHZ       = 200;
    localparam int TICK_CYCLES   = DELAY_BASE_US * CLK_MHZ;

    // Analog filter: sample count is 2^exponent, up to 8
    localparam int          AFCNT_W        = 2;
    localparam logic [1:0]  AFCNT_RST      = 2'h3;
    localparam int          HIST_DEPTH     = 8;
    localparam int          HIST_PTR_W     = 3;
    localparam logic [15:0] DEADBAND_RST   = 16'h0040;
    localparam int          ONBOARD_FIRST  = 0;
    localparam int          ONBOARD_SECOND = 1;

endpackage

// ===== rtl/input_conditioning_filters.sv
/*
  Input conditioning: digital delay filter with pulse catch and scan image,
  plus a moving-average analog filter with deadband step response fed
  through a sample FIFO.
  Assumes field inputs are asynchronous, scan_start_i and the analog sample
  stream are on core_clk_i, and reset is synchronous active high.
*/
// The address map and the plain strobed port were chosen for this implementation.
`timescale 1ns/1ps

module sample_fifo
#(
    parameter int W     = 18,
    parameter int DEPTH = 16
)
(
    input  wire logic         core_clk_i,
    input  wire logic         rst_i,
    input  wire logic         in_valid_i,
    output logic              in_ready_o,
    input  wire logic [W-1:0] in_data_i,
    output logic              out_valid_o,
    input  wire logic         out_ready_i,
    output logic [W-1:0]      out_data_o
);
    localparam int PW = $clog2(DEPTH);

    typedef struct packed {
        logic [DEPTH-1:0][W-1:0] mem;
        logic [PW-1:0]           wp;
        logic [PW-1:0]           rp;
        logic [PW:0]             cnt;
    } fifo_state_t;

    fifo_state_t state_reg;
    fifo_state_t state_next;
    logic        push;
    logic        pop;

    assign in_ready_o  = state_reg.cnt != (PW+1)'(DEPTH);
    assign out_valid_o = state_reg.cnt != '0;
    assign out_data_o  = state_reg.mem[state_reg.rp];
    assign push        = in_valid_i && in_ready_o;
    assign pop         = out_valid_o && out_ready_i;

    always_comb
    begin
        state_next = state_reg;
        if (push)
        begin
            state_next.mem[state_reg.wp] = in_data_i;
            state_next.wp = state_reg.wp + 1'b1;
        end
        if (pop)
        begin
            state_next.rp = state_reg.rp + 1'b1;
        end
        state_next.cnt = state_reg.cnt + (PW+1)'(push) - (PW+1)'(pop);
        if (rst_i)
        begin
            state_next.wp  = '0;
            state_next.rp  = '0;
            state_next.cnt = '0;
        end
    end

    always_ff @(posedge core_clk_i)
    begin
        state_reg <= state_next;
    end
endmodule

module input_conditioning_filters
    import input_cond_pkg::*;
#(
    parameter int N_DIN       = 8,
    parameter int N_GRP       = 2,
    parameter int N_AIN       = 4,
    parameter int AW          = 16,
    parameter int FIFO_DEPTH  = 16,
    parameter int TICK_CYCLES_P = TICK_CYCLES
)
(
    input  wire logic                     core_clk_i,
    input  wire logic                     rst_i,
    input  wire logic [7:0]               addr_i,
    input  wire logic [31:0]              wdata_i,
    input  wire logic                     wr_i,
    input  wire logic                     rd_i,
    output logic [31:0]                   rdata_o,
    input  wire logic [N_DIN-1:0]         din_pin_i,
    input  wire logic                     scan_start_i,
    output logic [N_DIN-1:0]              din_image_o,
    output logic [N_DIN-1:0]              din_filt_o,
    output logic [N_DIN-1:0]              hsc_in_o,
    input  wire logic                     sample_valid_i,
    output logic                          sample_ready_o,
    input  wire logic [$clog2(N_AIN)-1:0] sample_chan_i,
    input  wire logic [AW-1:0]            sample_data_i,
    output logic                          ain_valid_o,
    input  wire logic                     ain_ready_i,
    output logic [$clog2(N_AIN)-1:0]      ain_chan_o,
    output logic [AW-1:0]                 ain_data_o
);
    localparam int CW  = $clog2(N_AIN);
    localparam int TW  = $clog2(TICK_CYCLES_P + 1);
    localparam int SW  = AW + HIST_PTR_W;
    localparam int GS  = N_DIN / N_GRP;
    localparam logic [N_AIN-1:0] AFEN_RST =
        ~((N_AIN'(1) << ONBOARD_FIRST) | (N_AIN'(1) << ONBOARD_SECOND));

    typedef struct packed {
        logic [N_DIN-1:0]                          s1;
        logic [N_DIN-1:0]                          s2;
        logic [N_DIN-1:0]                          s3;
        logic [N_DIN-1:0]                          raw;
        logic [N_DIN-1:0]                          filt;
        logic [N_DIN-1:0]                          image;
        logic [N_DIN-1:0]                          caught;
        logic [N_DIN-1:0]                          cval;
        logic [N_DIN-1:0][DELAY_TICKS_W-1:0]       dcnt;
        logic [TW-1:0]                             pre;
        logic                                      tick;
        logic [N_GRP-1:0][DELAY_CODE_W-1:0]        dcode;
        logic [N_DIN-1:0]                          pce;
        logic [N_AIN-1:0]                          afen;
        logic [N_AIN-1:0]                          primed;
        logic [AFCNT_W-1:0]                        kexp;
        logic [AW-1:0]                             dband;
        logic [N_AIN-1:0][HIST_DEPTH-1:0][AW-1:0]  hist;
        logic [N_AIN-1:0][HIST_PTR_W-1:0]          wp;
        logic [N_AIN-1:0][SW-1:0]                  sum;
        logic [N_AIN-1:0][AW-1:0]                  favg;
        logic                                      ovalid;
        logic [CW-1:0]                             ochan;
        logic [AW-1:0]                             odata;
        logic [31:0]                               rdata;
    } state_t;

    state_t          state_reg;
    state_t          state_next;
    logic            fifo_valid;
    logic            fifo_ready;
    logic [CW+AW-1:0] fifo_data;

    // Target tick count for a delay code
    function automatic logic [DELAY_TICKS_W-1:0] delay_ticks(
        input logic [DELAY_CODE_W-1:0] code);
        delay_ticks = DELAY_TICKS_W'(1) << code;
    endfunction

    // Output port stalls the filter, which backs up the FIFO to the source
    assign fifo_ready = !state_reg.ovalid || ain_ready_i;

    sample_fifo
    #(
        .W     (CW + AW),
        .DEPTH (FIFO_DEPTH)
    )
    u_fifo
    (
        .core_clk_i  (core_clk_i),
        .rst_i       (rst_i),
        .in_valid_i  (sample_valid_i),
        .in_ready_o  (sample_ready_o),
        .in_data_i   ({sample_chan_i, sample_data_i}),
        .out_valid_o (fifo_valid),
        .out_ready_i (fifo_ready),
        .out_data_o  (fifo_data)
    );

    assign rdata_o     = state_reg.rdata;
    assign din_image_o = state_reg.image;
    assign din_filt_o  = state_reg.filt;
    assign hsc_in_o    = state_reg.raw;
    assign ain_valid_o = state_reg.ovalid;
    assign ain_chan_o  = state_reg.ochan;
    assign ain_data_o  = state_reg.odata;

    always_comb
    begin
        logic [CW-1:0]             c;
        logic [AW-1:0]             x;
        logic [AW-1:0]             oldest;
        logic signed [AW:0]        d;
        logic signed [AW:0]        mag;
        logic signed [SW-1:0]      nsum;
        logic [HIST_PTR_W-1:0]     oidx;
        logic [DELAY_TICKS_W-1:0]  cnt1;
        logic [DELAY_CODE_W-1:0]   code;
        c          = fifo_data[CW+AW-1:AW];
        x          = fifo_data[AW-1:0];
        oldest     = '0;
        d          = '0;
        mag        = '0;
        nsum       = '0;
        oidx       = '0;
        cnt1       = '0;
        code       = '0;
        state_next = state_reg;

        // Three-stage synchroniser; a change counts once stages 2 and 3 agree
        state_next.s1 = din_pin_i;
        state_next.s2 = state_reg.s1;
        state_next.s3 = state_reg.s2;
        for (int i = 0; i < N_DIN; i++)
        begin
            if (state_reg.s2[i] == state_reg.s3[i])
            begin
                state_next.raw[i] = state_reg.s3[i];
            end
        end

        // Free-running step of the base delay; up to one step of jitter
        state_next.tick = 1'b0;
        if (state_reg.pre == TW'(TICK_CYCLES_P - 1))
        begin
            state_next.pre  = '0;
            state_next.tick = 1'b1;
        end
        else
        begin
            state_next.pre = state_reg.pre + 1'b1;
        end

        for (int i = 0; i < N_DIN; i++)
        begin
            code = state_reg.dcode[i / GS];
            if (state_reg.raw[i] == state_reg.filt[i])
            begin
                state_next.dcnt[i] = '0;
            end
            else
            begin
                cnt1 = state_reg.dcnt[i] + DELAY_TICKS_W'(state_reg.tick);
                if (cnt1 >= delay_ticks(code))
                begin
                    state_next.filt[i] = state_reg.raw[i];
                    state_next.dcnt[i] = '0;
                end
                else
                begin
                    state_next.dcnt[i] = cnt1;
                end
            end
        end

        // Pulse catch works on the filtered level, first change only
        for (int i = 0; i < N_DIN; i++)
        begin
            if (state_reg.pce[i] && !state_reg.caught[i]
                && state_reg.filt[i] != state_reg.image[i])
            begin
                state_next.caught[i] = 1'b1;
                state_next.cval[i]   = state_reg.filt[i];
            end
        end
        if (scan_start_i)
        begin
            for (int i = 0; i < N_DIN; i++)
            begin
                state_next.image[i] = state_reg.caught[i] ? state_reg.cval[i]
                                                          : state_reg.filt[i];
            end
            state_next.caught = '0;
        end

        // Analog filter engine, one sample per accepted FIFO word
        if (state_reg.ovalid && ain_ready_i)
        begin
            state_next.ovalid = 1'b0;
        end
        if (fifo_valid && fifo_ready)
        begin
            state_next.ovalid = 1'b1;
            state_next.ochan  = c;
            state_next.odata  = x;
            d   = (AW+1)'($signed(x)) - (AW+1)'($signed(state_reg.favg[c]));
            mag = (d < 0) ? -d : d;
            if (state_reg.afen[c])
            begin
                if (!state_reg.primed[c] || mag > $signed({1'b0, state_reg.dband}))
                begin
                    // Step response refills the whole history with the new sample
                    for (int j = 0; j < HIST_DEPTH; j++)
                    begin
                        state_next.hist[c][j] = x;
                    end
                    state_next.sum[c]    = SW'($signed(x)) <<< state_reg.kexp;
                    state_next.favg[c]   = x;
                    state_next.primed[c] = 1'b1;
                    state_next.odata     = x;
                end
                else
                begin
                    oidx   = state_reg.wp[c] - (HIST_PTR_W'(1) << state_reg.kexp);
                    oldest = state_reg.hist[c][oidx];
                    nsum   = $signed(state_reg.sum[c]) - SW'($signed(oldest))
                           + SW'($signed(x));
                    state_next.hist[c][state_reg.wp[c]] = x;
                    state_next.wp[c]   = state_reg.wp[c] + 1'b1;
                    state_next.sum[c]  = nsum;
                    state_next.favg[c] = AW'(nsum >>> state_reg.kexp);
                    state_next.odata   = AW'(nsum >>> state_reg.kexp);
                end
            end
        end

        // Register port; reads answer in the following cycle
        state_next.rdata = '0;
        if (rd_i)
        begin
            unique case (addr_i)
                DELAY_REG:
                begin
                    for (int g = 0; g < N_GRP; g++)
                    begin
                        state_next.rdata[g*DELAY_FIELD_W +: DELAY_CODE_W] =
                            state_reg.dcode[g];
                    end
                end
                PCATCH_REG:   state_next.rdata[N_DIN-1:0] = state_reg.pce;
                AFEN_REG:     state_next.rdata[N_AIN-1:0] = state_reg.afen;
                AFCNT_REG:    state_next.rdata[AFCNT_W-1:0] = state_reg.kexp;
                DEADBAND_REG: state_next.rdata[AW-1:0] = state_reg.dband;
                RAW_REG:      state_next.rdata[N_DIN-1:0] = state_reg.raw;
                FILT_REG:     state_next.rdata[N_DIN-1:0] = state_reg.filt;
                IMAGE_REG:    state_next.rdata[N_DIN-1:0] = state_reg.image;
                default:      state_next.rdata = '0;
            endcase
        end
        if (wr_i)
        begin
            unique case (addr_i)
                DELAY_REG:
                begin
                    for (int g = 0; g < N_GRP; g++)
                    begin
                        code = wdata_i[g*DELAY_FIELD_W +: DELAY_CODE_W];
                        // Codes past the longest delay clamp to it
                        state_next.dcode[g] = (code > DELAY_CODE_MAX) ? DELAY_CODE_MAX
                                                                      : code;
                    end
                end
                PCATCH_REG:   state_next.pce = wdata_i[N_DIN-1:0];
                AFEN_REG:
                begin
                    state_next.afen   = wdata_i[N_AIN-1:0];
                    state_next.primed = '0;
                end
                AFCNT_REG:
                begin
                    // New window length restarts every average from next sample
                    state_next.kexp   = wdata_i[AFCNT_W-1:0];
                    state_next.primed = '0;
                end
                DEADBAND_REG: state_next.dband = wdata_i[AW-1:0];
                default:      state_next.dband = state_reg.dband;
            endcase
        end

        if (rst_i)
        begin
            state_next        = '0;
            state_next.dcode  = {N_GRP{DELAY_CODE_RST}};
            state_next.afen   = AFEN_RST;
            state_next.kexp   = AFCNT_RST;
            state_next.dband  = DEADBAND_RST[AW-1:0];
        end
    end

    always_ff @(posedge core_clk_i)
    begin
        state_reg <= state_next;
    end
endmodule

// ===== tb/input_cond_assertions.sv
/*
  Port-level checker for input_conditioning_filters, bound to the top module.
  Assumes one clock, core_clk_i, and synchronous active-high rst_i.
*/
`timescale 1ns/1ps
module input_cond_assertions
    import input_cond_pkg::*;
#(
    parameter int N_DIN = 8,
    parameter int N_AIN = 4,
    parameter int AW    = 16
)
(
    input wire logic                     core_clk_i,
    input wire logic                     rst_i,
    input wire logic [7:0]               addr_i,
    input wire logic [31:0]              wdata_i,
    input wire logic                     wr_i,
    input wire logic                     rd_i,
    input wire logic [31:0]              rdata_o,
    input wire logic [N_DIN-1:0]         din_pin_i,
    input wire logic                     scan_start_i,
    input wire logic [N_DIN-1:0]         din_image_o,
    input wire logic [N_DIN-1:0]         din_filt_o,
    input wire logic [N_DIN-1:0]         hsc_in_o,
    input wire logic                     sample_valid_i,
    input wire logic                     sample_ready_o,
    input wire logic [$clog2(N_AIN)-1:0] sample_chan_i,
    input wire logic [AW-1:0]            sample_data_i,
    input wire logic                     ain_valid_o,
    input wire logic                     ain_ready_i,
    input wire logic [$clog2(N_AIN)-1:0] ain_chan_o,
    input wire logic [AW-1:0]            ain_data_o
);
    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (rst_i);

    // Words accepted but not yet taken at the output: FIFO plus output stage
    logic [5:0] pend_reg;
    wire        push = sample_valid_i && sample_ready_o;
    wire        pop  = ain_valid_o && ain_ready_i;

    always_ff @(posedge core_clk_i)
    begin
        if (rst_i)
        begin
            pend_reg <= 6'h0;
        end
        else
        begin
            pend_reg <= pend_reg + {5'h0, push} - {5'h0, pop};
        end
    end

    sequence s_push;
        sample_valid_i && sample_ready_o;
    endsequence

    a_rdata_idle: assert property (!rd_i |=> rdata_o == 32'h0)
        else $error("read data not zero outside a read");
    a_filt_read: assert property (rd_i && addr_i == FILT_REG |=>
        rdata_o == {{(32-N_DIN){1'b0}}, $past(din_filt_o)}) else $error("filtered read wrong");
    a_image_read: assert property (rd_i && addr_i == IMAGE_REG |=>
        rdata_o == {{(32-N_DIN){1'b0}}, $past(din_image_o)}) else $error("image read wrong");
    a_image_scan: assert property ($changed(din_image_o) |-> $past(scan_start_i))
        else $error("image changed without scan start");
    a_hsc_follow: assert property ($stable(din_pin_i)[*6] |-> hsc_in_o == din_pin_i)
        else $error("counter inputs do not follow pins");
    a_filt_source: assert property ($changed(din_filt_o) |->
        ((din_filt_o ^ $past(din_filt_o)) & (din_filt_o ^ hsc_in_o)) == '0)
        else $error("filter moved away from input level");
    a_ain_hold: assert property (ain_valid_o && !ain_ready_i |=>
        ain_valid_o && $stable(ain_data_o) && $stable(ain_chan_o)) else $error("result dropped");
    // Queue words are those pending minus the one held at the output
    a_full_count: assert property (!sample_ready_o == (pend_reg - {5'h0, ain_valid_o} == 6'h10))
        else $error("FIFO full flag disagrees with sixteen held words");
    a_push_latency: assert property (s_push ##0 pend_reg == 6'h0 |-> ##2 ain_valid_o)
        else $error("result late after push");
    a_out_source: assert property (ain_valid_o |-> pend_reg != 6'h0)
        else $error("result without a sample");
endmodule

bind input_conditioning_filters input_cond_assertions #(.N_DIN(N_DIN), .N_AIN(N_AIN), .AW(AW))
    u_chk (.core_clk_i(core_clk_i), .rst_i(rst_i), .addr_i(addr_i), .wdata_i(wdata_i),
    .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .din_pin_i(din_pin_i),
    .scan_start_i(scan_start_i), .din_image_o(din_image_o), .din_filt_o(din_filt_o),
    .hsc_in_o(hsc_in_o), .sample_valid_i(sample_valid_i), .sample_ready_o(sample_ready_o),
    .sample_chan_i(sample_chan_i), .sample_data_i(sample_data_i), .ain_valid_o(ain_valid_o),
    .ain_ready_i(ain_ready_i), .ain_chan_o(ain_chan_o), .ain_data_o(ain_data_o));

// ===== tb/sample_source.sv
/*
  Converter sample source: queued samples offered with valid/ready.
  Assumes the consumer samples ready on core_clk_i rising edges.
*/
`timescale 1ns/1ps
module sample_source
(
    input  wire logic   core_clk_i,
    input  wire logic   rst_i,
    input  wire logic   ready_i,
    output logic        valid_o,
    output logic [1:0]  chan_o,
    output logic [15:0] data_o
);
    logic [17:0] q[$];

    task automatic send(input logic [1:0] c, input logic [15:0] d);
        q.push_back({c, d});
    endtask

    // Idle lines toggle so a stale word is never mistaken for a fresh one
    always @(posedge core_clk_i)
    begin
        if (rst_i)
        begin
            valid_o          <= 1'b0;
            {chan_o, data_o} <= 18'h0;
        end
        else if (valid_o && !ready_i)
            valid_o <= 1'b1;
        else if (q.size() > 0)
        begin
            {chan_o, data_o} <= q.pop_front();
            valid_o <= 1'b1;
        end
        else
        begin
            valid_o <= 1'b0;
            {chan_o, data_o} <= ~{chan_o, data_o};
        end
    end
endmodule

// ===== tb/test_input_conditioning_filters.sv
/*
  Self-checking bench for input_conditioning_filters.
  Assumes a 200 MHz clock and a tick of four cycles to keep delays short.
*/
`timescale 1ns/1ps
module test_input_conditioning_filters;
    import input_cond_pkg::*;
    logic        core_clk_i, rst_i, wr_i, rd_i, scan_start_i, ain_ready_i;
    logic        sample_valid_i, sample_ready_o, ain_valid_o;
    logic [7:0]  addr_i, din_pin_i, din_image_o, din_filt_o, hsc_in_o;
    logic [31:0] wdata_i, rdata_o;
    logic [1:0]  sample_chan_i, ain_chan_o;
    logic [15:0] sample_data_i, ain_data_o;
    logic [17:0] outq[$];
    int          err_count, n_tests, i;

    input_conditioning_filters #(.TICK_CYCLES_P(4)) dut (.core_clk_i(core_clk_i),
        .rst_i(rst_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i),
        .rdata_o(rdata_o), .din_pin_i(din_pin_i), .scan_start_i(scan_start_i),
        .din_image_o(din_image_o), .din_filt_o(din_filt_o), .hsc_in_o(hsc_in_o),
        .sample_valid_i(sample_valid_i), .sample_ready_o(sample_ready_o),
        .sample_chan_i(sample_chan_i), .sample_data_i(sample_data_i),
        .ain_valid_o(ain_valid_o), .ain_ready_i(ain_ready_i), .ain_chan_o(ain_chan_o),
        .ain_data_o(ain_data_o));
    sample_source src (.core_clk_i(core_clk_i), .rst_i(rst_i), .ready_i(sample_ready_o),
        .valid_o(sample_valid_i), .chan_o(sample_chan_i), .data_o(sample_data_i));

    initial
    begin
        core_clk_i = 1'b0;
        forever #2.5 core_clk_i = ~core_clk_i;
    end

    always @(posedge core_clk_i)
        if (!rst_i && ain_valid_o && ain_ready_i)
            outq.push_back({ain_chan_o, ain_data_o});

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp)
        begin
            err_count++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge core_clk_i);
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge core_clk_i);
        addr_i  <= a;
        wdata_i <= d;
        wr_i    <= 1'b1;
        @(posedge core_clk_i);
        wr_i <= 1'b0;
    endtask

    task automatic rdc(input logic [7:0] a, input logic [31:0] e);
        @(posedge core_clk_i);
        addr_i <= a;
        rd_i   <= 1'b1;
        @(posedge core_clk_i);
        rd_i <= 1'b0;
        @(posedge core_clk_i);
        check(rdata_o, e);
    endtask

    task automatic pin(input logic [7:0] v, input int n);
        @(posedge core_clk_i);
        din_pin_i <= v;
        cyc(n);
    endtask

    // Image updates on the edge that takes the scan pulse and is checked one edge later
    task automatic scan(input logic [7:0] e);
        @(posedge core_clk_i);
        scan_start_i <= 1'b1;
        @(posedge core_clk_i);
        scan_start_i <= 1'b0;
        @(posedge core_clk_i);
        check({24'h0, din_image_o}, {24'h0, e});
    endtask

    task automatic expo(input logic [1:0] c, input logic [15:0] d);
        int k;
        for (k = 0; k < 100 && outq.size() == 0; k++)
            @(posedge core_clk_i);
        if (outq.size() == 0)
            check(32'hffffffff, {14'h0, c, d});
        else
            check({14'h0, outq.pop_front()}, {14'h0, c, d});
    endtask

    task automatic sx(input logic [1:0] c, input logic [15:0] d, input logic [15:0] e);
        src.send(c, d);
        expo(c, e);
    endtask

    task automatic conclude;
        $display("comparisons=%0d mismatches=%0d", n_tests, err_count);
        if (err_count == 0 && n_tests > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    // Tests need about a thousand cycles; far more means a hang
    initial
    begin
        cyc(40000);
        err_count++;
        conclude();
    end

    initial
    begin
        {wr_i, rd_i, scan_start_i, addr_i, wdata_i, din_pin_i} = '0;
        rst_i       = 1'b1;
        ain_ready_i = 1'b1;
        err_count   = 0;
        n_tests     = 0;
        cyc(8);
        rst_i <= 1'b0;
        rdc(DELAY_REG, 32'h55);
        rdc(PCATCH_REG, 32'h0);
        rdc(AFEN_REG, 32'hc);
        rdc(AFCNT_REG, 32'h3);
        rdc(DEADBAND_REG, 32'h40);
        wr(8'h20, 32'hff);
        rdc(8'h20, 32'h0);
        wr(DELAY_REG, 32'h70);
        rdc(DELAY_REG, 32'h60);
        pin(8'h01, 12);
        check({24'h0, din_filt_o}, 32'h01);
        pin(8'h11, 100);
        check({24'h0, hsc_in_o}, 32'h11);
        rdc(RAW_REG, 32'h11);
        pin(8'h01, 300);
        check({24'h0, din_filt_o}, 32'h01);
        pin(8'h11, 240);
        check({24'h0, din_filt_o}, 32'h01);
        cyc(40);
        check({24'h0, din_filt_o}, 32'h11);
        rdc(FILT_REG, 32'h11);
        rdc(IMAGE_REG, 32'h0);
        wr(PCATCH_REG, 32'h1);
        scan(8'h11);
        pin(8'h12, 20);
        pin(8'h11, 20);
        scan(8'h10);
        scan(8'h11);
        pin(8'h10, 20);
        scan(8'h10);
        for (i = 0; i < 2; i++)
        begin
            pin(8'h11, 20);
            pin(8'h10, 20);
        end
        scan(8'h11);
        sx(2'h0, 16'h1234, 16'h1234);
        sx(2'h2, 16'h0100, 16'h0100);
        sx(2'h2, 16'h0108, 16'h0101);
        sx(2'h2, 16'h0200, 16'h0200);
        wr(AFCNT_REG, 32'h1);
        sx(2'h3, 16'h0010, 16'h0010);
        sx(2'h3, 16'h0013, 16'h0011);
        wr(DEADBAND_REG, 32'h10);
        sx(2'h3, 16'h0024, 16'h0024);
        sx(2'h3, 16'h0030, 16'h002a);
        wr(AFEN_REG, 32'h1);
        sx(2'h2, 16'h0555, 16'h0555);
        sx(2'h0, 16'h0800, 16'h0800);
        sx(2'h0, 16'h0804, 16'h0802);
        wr(AFCNT_REG, 32'h2);
        sx(2'h0, 16'h0100, 16'h0100);
        sx(2'h0, 16'h0104, 16'h0101);
        wr(AFCNT_REG, 32'h0);
        sx(2'h0, 16'h0010, 16'h0010);
        sx(2'h0, 16'h0018, 16'h0018);
        // Consumer stalls: output stage plus sixteen FIFO words fill up
        ain_ready_i <= 1'b0;
        for (i = 0; i < 18; i++)
            src.send(2'h1, i[15:0]);
        cyc(40);
        check({31'h0, sample_ready_o}, 32'h0);
        ain_ready_i <= 1'b1;
        for (i = 0; i < 18; i++)
            expo(2'h1, i[15:0]);
        conclude();
    end
endmodule
